// ===== verilog/scb_bus_control.sv
/*
  system bus control: status latch, control strobes, address buffer
  enables and ready control between a processor local bus and a
  ROM/RAM/port system bus.
  assumes all inputs synchronous to ref_clk_i; state_en_i marks each
  processor clock state; bus_enable_i low during DMA.
*/
// Behaviour
// - status byte latched from data lines on each status strobe.
// - memory and port strobes from latched status with read and write strobes.
// - interrupt acknowledge strobe is status bit gated with data-bus-in.
// - write-output, stack and opcode-fetch status are driven on control bus.
// - address buffers released to high impedance while bus enable is low.
// - read: address in first two states, data gated in third.
// - write: address in first two states, write strobe in third.
// - fast memories need no wait; ready held high.
// - slow memories get whole-state wait states through ready.
// - one wait state gives a five-state, 2.5 us instruction cycle.
// - isolated mode: port strobes only from in/out cycles.
// - mapped mode: port strobes are memory strobes gated with top bit.
// - mapped mode: top bit zero is memory, one is port.
// - mapped mode limits memory space to 32K.
// - mapped mode: any memory instruction reaches ports, bus unchanged.
`timescale 1ns/1ps
module scb_bus_control #(
  parameter logic [3:0] WAIT_STATES = 4'(scb_pkg::WAIT_STATES_DEF)
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic status_latch_strobe_i,
  input wire logic state_en_i,
  input wire logic [7:0] cpu_data_i,
  input wire logic data_bus_in_strobe_i,
  input wire logic write_strobe_n_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic bus_enable_i,
  input wire logic memory_mapped_io_i,
  input wire logic slow_memory_i,
  output logic memory_read_strobe_o,
  output logic memory_write_strobe_o,
  output logic port_read_strobe_o,
  output logic port_write_strobe_o,
  output logic interrupt_acknowledge_strobe_o,
  output logic write_output_status_o,
  output logic stack_status_o,
  output logic opcode_fetch_status_o,
  output logic [15:0] addr_o,
  output logic [15:0] addr_oe_o,
  output logic ready_o
);
  // ******************************************************************
  // status latch and ready control
  // ******************************************************************
  logic [7:0] status;
  logic ready_c;

  scb_status_latch u_latch (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .status_latch_strobe_i(status_latch_strobe_i),
    .data_i(cpu_data_i),
    .status_o(status)
  );

  // waits follow slow_memory_i at the status strobe, whatever the cycle type, port cycles included
  scb_wait_ctl #(
    .WAIT_STATES(WAIT_STATES)
  ) u_wait (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .status_latch_strobe_i(status_latch_strobe_i),
    .state_en_i(state_en_i),
    .slow_sel_i(slow_memory_i),
    .ready_o(ready_c)
  );

  // ******************************************************************
  // command decode
  // ******************************************************************
  logic wr_act;
  logic s_memory_read_strobe;
  logic s_inp;
  logic s_out;
  logic s_interrupt_acknowledge_strobe;
  logic s_wo_n;
  logic top;
  logic next_memory_read_strobe;
  logic next_memory_write_strobe;
  logic next_ior;
  logic next_iow;
  logic next_interrupt_acknowledge_strobe;
  logic [15:0] next_addr;
  logic [15:0] next_addr_oe;

  assign wr_act = !write_strobe_n_i;
  assign s_memory_read_strobe = status[scb_pkg::STAT_MEMORY_READ_STROBE_BIT];
  assign s_inp = status[scb_pkg::STAT_INP_BIT];
  assign s_out = status[scb_pkg::STAT_OUT_BIT];
  assign s_interrupt_acknowledge_strobe = status[scb_pkg::STAT_INTERRUPT_ACKNOWLEDGE_STROBE_BIT];
  assign s_wo_n = status[scb_pkg::STAT_WO_BIT];
  assign top = cpu_addr_i[scb_pkg::TOP_BIT];

  // memory write is a write cycle that is neither port output nor acknowledge
  function automatic logic is_mem_write(input logic [7:0] st);
    is_mem_write = !st[scb_pkg::STAT_WO_BIT] && !st[scb_pkg::STAT_OUT_BIT]
      && !st[scb_pkg::STAT_INTERRUPT_ACKNOWLEDGE_STROBE_BIT];
  endfunction

  // strobes follow data-bus-in and write within the third state; one at most
  always_comb begin
    logic mem_rd;
    logic mem_wr;
    mem_rd = s_memory_read_strobe && data_bus_in_strobe_i;
    mem_wr = is_mem_write(status) && wr_act;
    next_interrupt_acknowledge_strobe = s_interrupt_acknowledge_strobe && data_bus_in_strobe_i;
    if (memory_mapped_io_i) begin
      // top bit splits memory from ports; memory below 32K
      next_memory_read_strobe = mem_rd && !top;
      next_memory_write_strobe = mem_wr && !top;
      next_ior = mem_rd && top; // any memory instruction reaches ports
      next_iow = mem_wr && top;
    end else begin
      // isolated: only in/out cycles drive port strobes, full space kept
      next_memory_read_strobe = mem_rd;
      next_memory_write_strobe = mem_wr;
      // a status byte with both read kinds set must not raise two strobes
      next_ior = s_inp && !s_memory_read_strobe && data_bus_in_strobe_i;
      next_iow = s_out && wr_act;
    end
    if (next_interrupt_acknowledge_strobe) begin
      // acknowledge excludes every other command
      next_memory_read_strobe = 1'b0;
      next_ior = 1'b0;
    end
    if (next_memory_read_strobe || next_ior || next_interrupt_acknowledge_strobe) begin
      next_memory_write_strobe = 1'b0; // a read cycle never writes
      next_iow = 1'b0;
    end
    next_addr = cpu_addr_i;
    next_addr_oe = bus_enable_i ? 16'hffff : 16'h0000; // released for dma
  end

  // ******************************************************************
  // output registers
  // ******************************************************************
  // registered outputs cost one reference clock of lag, far below a state
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      memory_read_strobe_o <= 1'b0;
      memory_write_strobe_o <= 1'b0;
      port_read_strobe_o <= 1'b0;
      port_write_strobe_o <= 1'b0;
      interrupt_acknowledge_strobe_o <= 1'b0;
      write_output_status_o <= 1'b0;
      stack_status_o <= 1'b0;
      opcode_fetch_status_o <= 1'b0;
      addr_o <= 16'h0000;
      addr_oe_o <= 16'h0000;
      ready_o <= 1'b1;
    end else begin
      memory_read_strobe_o <= next_memory_read_strobe;
      memory_write_strobe_o <= next_memory_write_strobe;
      port_read_strobe_o <= next_ior;
      port_write_strobe_o <= next_iow;
      interrupt_acknowledge_strobe_o <= next_interrupt_acknowledge_strobe;
      write_output_status_o <= !s_wo_n;
      stack_status_o <= status[scb_pkg::STAT_STACK_BIT];
      opcode_fetch_status_o <= status[scb_pkg::STAT_M1_BIT];
      addr_o <= next_addr;
      addr_oe_o <= next_addr_oe;
      ready_o <= ready_c;
    end
  end

  // ******************************************************************
  // checks
  // ******************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_one_strobe: assert property (
    $onehot0({memory_read_strobe_o, memory_write_strobe_o, port_read_strobe_o,
    port_write_strobe_o, interrupt_acknowledge_strobe_o}))
    else $error("more than one command strobe active");
  a_latch_load: assert property (
    status_latch_strobe_i |=> status == $past(cpu_data_i))
    else $error("status not latched on strobe");
  a_interrupt_acknowledge_strobe_gate: assert property (
    s_interrupt_acknowledge_strobe && data_bus_in_strobe_i |=> interrupt_acknowledge_strobe_o)
    else $error("acknowledge strobe missing");
  a_interrupt_acknowledge_strobe_cause: assert property (
    interrupt_acknowledge_strobe_o |-> $past(data_bus_in_strobe_i))
    else $error("acknowledge without data-bus-in");
  a_dma_release: assert property (!bus_enable_i |=> addr_oe_o == 16'h0000)
    else $error("address driven during dma");
  a_mapped_port: assert property (
    memory_mapped_io_i && port_read_strobe_o |-> $past(top) && $past(s_memory_read_strobe))
    else $error("mapped port read without top bit");
  a_mapped_mem: assert property (
    memory_mapped_io_i && $past(memory_mapped_io_i) && memory_read_strobe_o |-> !$past(top))
    else $error("mapped memory read above 32K");
  a_iso_port: assert property (
    !memory_mapped_io_i && $past(!memory_mapped_io_i) && port_write_strobe_o |-> $past(s_out))
    else $error("isolated port write without output status");
  a_write_gate: assert property (memory_write_strobe_o |-> $past(wr_act))
    else $error("memory write without write strobe");
  a_slow_wait: assert property (status_latch_strobe_i && slow_memory_i |=> !ready_o)
    else $error("no wait state for slow memory");
  a_fast_ready: assert property (
    status_latch_strobe_i && !slow_memory_i |=> ready_o[*2])
    else $error("wait state on fast memory");

  c_mem_read: cover property (memory_read_strobe_o);
  c_port_write: cover property (port_write_strobe_o);
  c_interrupt_acknowledge_strobe: cover property (interrupt_acknowledge_strobe_o);
  c_wait: cover property (!ready_o ##1 ready_o);
endmodule

// ===== pkg/scb_pkg.sv
/*
  shared constants of the system bus control block: status byte bit positions,
  reset values and wait-state timing.
  assumes a single 100 MHz clock; no other package is used.
*/
package scb_pkg;
  // ******************************************************************
  // status byte bit positions, latched from the processor data lines
  // ******************************************************************
  localparam int unsigned STAT_INTERRUPT_ACKNOWLEDGE_STROBE_BIT = 0; // interrupt acknowledge
  localparam int unsigned STAT_WO_BIT = 1;   // write-output, active low
  localparam int unsigned STAT_STACK_BIT = 2;
  localparam int unsigned STAT_HLTA_BIT = 3;
  localparam int unsigned STAT_OUT_BIT = 4;  // port write cycle
  localparam int unsigned STAT_M1_BIT = 5;   // opcode fetch
  localparam int unsigned STAT_INP_BIT = 6;  // port read cycle
  localparam int unsigned STAT_MEMORY_READ_STROBE_BIT = 7; // memory read cycle
  localparam logic [7:0] STATUS_RESET = 8'h02; // write-output idle high
  // ******************************************************************
  // address and timing
  // ******************************************************************
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned TOP_BIT = 15;
  localparam int unsigned MAPPED_MEM_BYTES = 32768;   // memory left in mapped mode
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CPU_PERIOD_NS = 500;        // processor clock period
  localparam int unsigned REQ_ACCESS_NS = 550;        // upper bound of required access
  localparam int unsigned SLOW_ACCESS_NS = 850;       // slow memory access
  localparam int unsigned WAIT_STATES_DEF =
    (SLOW_ACCESS_NS - REQ_ACCESS_NS + CPU_PERIOD_NS - 1) / CPU_PERIOD_NS;
  localparam int unsigned CYCLE_WAIT_NS = 2500;       // instruction cycle with one wait
  localparam int unsigned CYCLE_WAIT_CLKS = CYCLE_WAIT_NS / CPU_PERIOD_NS; // 5 states
  localparam int unsigned WAIT_CNT_W = 4;
endpackage

// ===== verilog/scb_status_latch.sv
/*
  eight bit status latch, loaded on the status strobe at the start of
  every machine cycle.
  assumes the strobe is a one-cycle pulse synchronous to ref_clk_i.
*/
`timescale 1ns/1ps
module scb_status_latch (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic status_latch_strobe_i,
  input wire logic [7:0] data_i,
  output logic [7:0] status_o
);
  logic [7:0] next_status;

  // load only on the strobe, hold otherwise
  always_comb begin
    next_status = status_o;
    if (status_latch_strobe_i) begin
      next_status = data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_o <= scb_pkg::STATUS_RESET;
    end else begin
      status_o <= next_status;
    end
  end
endmodule

// ===== verilog/scb_wait_ctl.sv
/*
  ready control: counts wait states for slow memory accesses.
  assumes state_en_i pulses once per processor clock state and
  slow_sel_i is steady from the status strobe through the access.
*/
`timescale 1ns/1ps
module scb_wait_ctl #(
  parameter logic [3:0] WAIT_STATES = 4'(scb_pkg::WAIT_STATES_DEF)
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic status_latch_strobe_i,
  input wire logic state_en_i,
  input wire logic slow_sel_i,
  output logic ready_o
);
  logic [3:0] wait_cnt;
  logic [3:0] next_wait_cnt;

  // load the wait count at cycle start; burn one per state
  always_comb begin
    next_wait_cnt = wait_cnt;
    if (status_latch_strobe_i) begin
      next_wait_cnt = slow_sel_i ? WAIT_STATES : 4'h0;
    end else if (state_en_i && wait_cnt != 4'h0) begin
      next_wait_cnt = wait_cnt - 4'h1; // whole clock states only
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_cnt <= 4'h0;
    end else begin
      wait_cnt <= next_wait_cnt;
    end
  end

  // ready is high whenever no wait state is owed
  assign ready_o = (wait_cnt == 4'h0) && !(status_latch_strobe_i && slow_sel_i);
endmodule

// ===== testbench/scb_bus_devices.sv
/*
  partner model: memory, port and restart-instruction devices on the system bus.
  assumes registered strobes from the bus control block and write data from the bench.
*/
`timescale 1ns/1ps
module scb_bus_devices #(
  parameter logic [7:0] RESTART_OP = 8'h5a // arbitrary restart value
) (
  input wire logic ref_clk_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic port_rd_i,
  input wire logic port_wr_i,
  input wire logic interrupt_acknowledge_strobe_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [256];
  logic [7:0] port [256];
  // low lines index the array, upper lines would form the select
  always @(posedge ref_clk_i) begin
    if (mem_wr_i)
      mem[addr_i[7:0]] <= wdata_i;
    if (port_wr_i)
      port[addr_i[7:0]] <= wdata_i;
  end
  // a released data bus floats to its pull-ups, never a stale copy
  always_comb begin
    if (interrupt_acknowledge_strobe_i)
      rdata_o = RESTART_OP;
    else if (mem_rd_i)
      rdata_o = mem[addr_i[7:0]];
    else if (port_rd_i)
      rdata_o = port[addr_i[7:0]];
    else
      rdata_o = 8'hff;
  end
endmodule

// ===== testbench/cpu_system_bus_control_tb.sv
/*
  self-checking bench of the system bus control block.
  assumes scb_pkg is compiled first; waits are lengthened to two states.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, e); end end
module cpu_system_bus_control_tb;
  logic ref_clk_i, reset_n_i, status_latch_strobe_i, state_en_i;
  logic [7:0] cpu_data_i, dev_data;
  logic data_bus_in_strobe_i, write_strobe_n_i, bus_enable_i;
  logic memory_mapped_io_i, slow_memory_i, look;
  logic [15:0] cpu_addr_i, addr_o, addr_oe_o;
  logic memory_read_strobe, memory_write_strobe, ior, iow, interrupt_acknowledge_strobe, wo, stk, m1, ready_o;
  logic [31:0] rnd;
  logic [40:0] notes[$];
  logic [40:0] got, exp;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  localparam logic [7:0] RESTART_OP = 8'h5a; // arbitrary restart value
  // ************************************************************
  // design and partner
  // ************************************************************
  scb_bus_control #(.WAIT_STATES(4'h2)) dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .status_latch_strobe_i(status_latch_strobe_i), .state_en_i(state_en_i),
    .cpu_data_i(cpu_data_i), .data_bus_in_strobe_i(data_bus_in_strobe_i),
    .write_strobe_n_i(write_strobe_n_i), .cpu_addr_i(cpu_addr_i),
    .bus_enable_i(bus_enable_i), .memory_mapped_io_i(memory_mapped_io_i),
    .slow_memory_i(slow_memory_i), .memory_read_strobe_o(memory_read_strobe),
    .memory_write_strobe_o(memory_write_strobe), .port_read_strobe_o(ior), .port_write_strobe_o(iow),
    .interrupt_acknowledge_strobe_o(interrupt_acknowledge_strobe), .write_output_status_o(wo),
    .stack_status_o(stk), .opcode_fetch_status_o(m1), .addr_o(addr_o),
    .addr_oe_o(addr_oe_o), .ready_o(ready_o));
  scb_bus_devices #(.RESTART_OP(RESTART_OP)) devs (.ref_clk_i(ref_clk_i), .mem_rd_i(memory_read_strobe),
    .mem_wr_i(memory_write_strobe), .port_rd_i(ior), .port_wr_i(iow), .interrupt_acknowledge_strobe_i(interrupt_acknowledge_strobe), .addr_i(addr_o),
    .wdata_i(cpu_data_i), .rdata_o(dev_data));
  always #5 ref_clk_i = ~ref_clk_i;
  function automatic logic [31:0] lfsr_f(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic conclude();
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ************************************************************
  // one machine cycle: status strobe, then read or write level
  // ************************************************************
  task automatic mcycle(input logic [7:0] st, input logic a15, input logic wr,
                        input logic be, input logic [4:0] ex);
    logic [40:0] n;
    rnd = lfsr_f(rnd);
    @(posedge ref_clk_i);
    #1;
    status_latch_strobe_i = 1;
    cpu_data_i = st;
    cpu_addr_i = {a15, rnd[14:0]};
    bus_enable_i = be;
    @(posedge ref_clk_i);
    #1;
    status_latch_strobe_i = 0;
    cpu_data_i = rnd[23:16]; // junk after the strobe must not load
    @(posedge ref_clk_i);
    #1;
    data_bus_in_strobe_i = !wr;
    write_strobe_n_i = !wr;
    n = {ex, ~st[1], st[2], st[5], {16{be}}, cpu_addr_i, 1'b1};
    notes.push_back(n);
    repeat (2) @(posedge ref_clk_i);
    #1;
    look = 1;
    @(posedge ref_clk_i);
    #1;
    look = 0;
    data_bus_in_strobe_i = 0;
    write_strobe_n_i = 1;
    notes.push_back({5'h00, n[35:0]});
    repeat (2) @(posedge ref_clk_i);
    #1;
    look = 1;
    @(posedge ref_clk_i);
    #1;
    look = 0;
  endtask
  // watcher: compares outputs against the oldest note when one is due
  always @(negedge ref_clk_i) begin
    if (look && notes.size() > 0) begin
      got = {interrupt_acknowledge_strobe, memory_read_strobe, memory_write_strobe, ior, iow, wo, stk, m1, addr_oe_o, addr_o, ready_o};
      exp = notes.pop_front();
      `CHK(got, exp)
      // the acknowledge strobe must put the restart instruction on the bus
      if (interrupt_acknowledge_strobe)
        `CHK(dev_data, RESTART_OP)
    end
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      conclude();
    end
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {ref_clk_i, reset_n_i, status_latch_strobe_i, state_en_i, look} = 5'h00;
    {data_bus_in_strobe_i, write_strobe_n_i, bus_enable_i} = 3'h3;
    {memory_mapped_io_i, slow_memory_i, cpu_data_i, cpu_addr_i} = 26'h000_0000;
    rnd = 32'h4f0d;
    repeat (16) @(posedge ref_clk_i);
    #1;
    `CHK({ready_o, addr_oe_o, memory_read_strobe, interrupt_acknowledge_strobe}, {1'b1, 16'h0000, 2'h0})
    reset_n_i = 1;
    mcycle(8'ha2, 1, 0, 1, 5'h08);
    mcycle(8'h82, 0, 0, 0, 5'h08); // address released for dma
    mcycle(8'h00, 1, 1, 1, 5'h04);
    mcycle(8'h86, 0, 0, 1, 5'h08);
    mcycle(8'h04, 0, 1, 1, 5'h04);
    mcycle(8'h42, 0, 0, 1, 5'h02);
    mcycle(8'h10, 1, 1, 1, 5'h01);
    mcycle(8'h23, 0, 0, 1, 5'h10); // acknowledge only
    mcycle(8'h42, 0, 1, 1, 5'h00); // read status with write level
    mcycle(8'h10, 0, 0, 1, 5'h00); // output status with read level
    memory_mapped_io_i = 1;
    mcycle(8'h82, 0, 0, 1, 5'h08);
    mcycle(8'h00, 1, 1, 1, 5'h01);
    mcycle(8'h00, 0, 1, 1, 5'h04);
    mcycle(8'h42, 1, 0, 1, 5'h00);
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr_f(rnd);
      mcycle(8'h82, rnd[31], 0, 1, rnd[31] ? 5'h02 : 5'h08);
    end
    // slow access: ready drops and releases after two whole states
    @(posedge ref_clk_i);
    #1;
    status_latch_strobe_i = 1;
    cpu_data_i = 8'h82;
    slow_memory_i = 1;
    @(posedge ref_clk_i);
    #1;
    status_latch_strobe_i = 0;
    repeat (3) @(posedge ref_clk_i);
    #1;
    `CHK(ready_o, 1'b0)
    for (int i = 0; i < 2; i++) begin
      state_en_i = 1;
      @(posedge ref_clk_i);
      #1;
      state_en_i = 0;
      repeat (2) @(posedge ref_clk_i);
      #1;
      `CHK(ready_o, logic'(i == 1))
    end
    conclude();
  end
endmodule
